// *** src/modem_pkg.sv ***
// Purpose: Shared constants and types for the call termination control.
// Assumes: A 25 MHz system clock and a byte-wide character path.
// Notes: Offsets are byte addresses on the plain register port.
package modem_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int MS_PER_S = 1000;
  localparam logic [15:0] DROP_MIN_MS = 16'h0064;
  localparam logic [7:0] ANSWER_TIMEOUT_S = 8'h0a;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] ADDR_EOT_CNT = 8'h10;
  localparam logic [7:0] ADDR_CHAR_MS = 8'h14;
  localparam logic [7:0] ADDR_RX_LIMIT = 8'h18;
  localparam int CTRL_ANS = 0;
  localparam int CTRL_LEASED = 1;
  localparam int CTRL_RTS = 2;
  localparam int CTRL_BUSY = 3;
  localparam int CTRL_HANG = 4;
  localparam int CTRL_GO = 5;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [3:0] EOT_CNT_RST = 4'h3;
  localparam logic [15:0] CHAR_MS_RST = 16'h0064;
  localparam logic [15:0] RX_LIMIT_RST = 16'h0000;
  localparam int IRQ_W = 5;
  localparam int IRQ_CARRIER = 0;
  localparam int IRQ_EOT = 1;
  localparam int IRQ_TIMEOUT = 2;
  localparam int IRQ_ENDED = 3;
  localparam int IRQ_RING = 4;
  localparam logic [IRQ_W-1:0] IRQ_RST = 5'h00;
  localparam int STAT_STATE_LSB = 4;
  localparam logic [7:0] EOT_CHAR = 8'h04;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ANSWER = 3'b001,
    ST_CONN = 3'b011,
    ST_EOT = 3'b010,
    ST_DRAIN = 3'b110,
    ST_DROP = 3'b111
  } state_t;
endpackage : modem_pkg

// *** src/tick_if.sv ***
// Purpose: Carries the slow timing ticks between the prescaler and the control.
// Assumes: Both ticks are one-cycle pulses on the system clock.
// Notes: The second tick coincides with a millisecond tick.
`timescale 1ns/10ps
interface tick_if;
  logic ms_tick;
  logic s_tick;
  modport src (output ms_tick, output s_tick);
  modport dst (input ms_tick, input s_tick);
endinterface : tick_if

// *** src/tick_gen.sv ***
// Purpose: Prescales the system clock into millisecond and second enables.
// Assumes: One clock domain.
// Notes: Parameters may be shortened in simulation.
`timescale 1ns/10ps
module tick_gen #(
  parameter int MS_CYCLES = 25000,
  parameter int MS_PER_S = 1000
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Tick outputs
  tick_if.src tk
);
  logic [$clog2(MS_CYCLES)-1:0] div_reg;
  logic [$clog2(MS_PER_S)-1:0] ms_reg;
  logic ms_tick_reg;
  logic s_tick_reg;
  wire div_end = (div_reg == ($clog2(MS_CYCLES))'(MS_CYCLES - 1));
  wire ms_end = (ms_reg == ($clog2(MS_PER_S))'(MS_PER_S - 1));

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      div_reg <= '0;
      ms_reg <= '0;
      ms_tick_reg <= 1'b0;
      s_tick_reg <= 1'b0;
    end else begin
      div_reg <= div_end ? '0 : div_reg + 1'b1;
      ms_tick_reg <= div_end;
      s_tick_reg <= div_end && ms_end;
      if (div_end) begin
        ms_reg <= ms_end ? '0 : ms_reg + 1'b1;
      end
    end
  end

  assign tk.ms_tick = ms_tick_reg;
  assign tk.s_tick = s_tick_reg;
endmodule : tick_gen

// *** src/in_sync.sv ***
// Purpose: Brings modem status pins into the clock domain.
// Assumes: Pins change slowly compared with the clock.
// Notes: A change is taken only once the second and third stages agree.
`timescale 1ns/10ps
module in_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Pins and clean levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q_reg <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg <= (s2_reg & s3_reg) | (q_reg & (s2_reg | s3_reg));
    end
  end

  assign q = q_reg;
endmodule : in_sync

// *** src/call_term_ctrl.sv ***
// Purpose: Ends modem calls: hang-up sequencing, timeouts and disconnect triggers.
// Assumes: Modem status pins are asynchronous; character strobes share the clock.
// Notes: Registers sit on a plain strobe port with read data one cycle later.
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/10ps
module call_term_ctrl
  import modem_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES,
  parameter int MS_S = MS_PER_S
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WE,
  input wire logic RE,
  output logic [31:0] RDATA,
  // Modem control and status
  output logic DTR,
  output logic RTS,
  input wire logic DSR,
  input wire logic DCD,
  input wire logic CTS,
  input wire logic RI,
  // Character path
  input wire logic RX_VALID,
  input wire logic [7:0] RX_DATA,
  output logic TX_VALID,
  output logic [7:0] TX_DATA,
  input wire logic TX_READY,
  // Interrupt
  output logic IRQ
);
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  tick_if tk ();
  logic [3:0] pins_s;
  state_t state_reg, state_next;
  logic [3:0] ctrl_reg;
  logic [3:0] eot_cnt_reg;
  logic [3:0] eot_left_reg;
  logic [15:0] char_ms_reg;
  logic [15:0] rx_limit_reg;
  logic [15:0] rx_cnt_reg;
  logic [15:0] ms_cnt_reg;
  logic [7:0] s_cnt_reg;
  logic [IRQ_W-1:0] irq_stat_reg, irq_stat_next;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [31:0] rdata_reg;
  logic dtr_reg;
  logic rts_reg;
  logic ri_d_reg;
  logic [31:0] drop_cyc_reg;

  tick_gen #(.MS_CYCLES(MS_CYC), .MS_PER_S(MS_S)) u_tick (
    .CLK(CLK),
    .RST(RST),
    .tk(tk)
  );

  in_sync #(.W(4)) u_sync (
    .CLK(CLK),
    .RST(RST),
    .d({RI, CTS, DCD, DSR}),
    .q(pins_s)
  );

  wire dsr_s = pins_s[0];
  wire dcd_s = pins_s[1];
  wire ri_s = pins_s[3];
  wire leased = ctrl_reg[CTRL_LEASED];
  wire wr_ctrl = WE && hit(ADDR, ADDR_CTRL);
  wire hang_cmd = wr_ctrl && WDATA[CTRL_HANG];
  wire go_cmd = wr_ctrl && WDATA[CTRL_GO];
  wire eot_rx = RX_VALID && (RX_DATA == EOT_CHAR);
  wire rx_lim_hit = (rx_limit_reg != 16'h0000) && (rx_cnt_reg >= rx_limit_reg);
  wire tx_fire = TX_VALID && TX_READY;
  wire ans_timeout = s_cnt_reg >= ANSWER_TIMEOUT_S;
  wire drop_done = (ms_cnt_reg > DROP_MIN_MS) && (leased || !dsr_s);
  wire st_change = (state_next != state_reg);
  wire busy_out = ctrl_reg[CTRL_BUSY];

  // Carrier loss is only trusted after the set's own lag, so no extra filter is added here.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (ri_s && ctrl_reg[CTRL_ANS]) begin
          state_next = ST_ANSWER;
        end else if (leased && dsr_s && go_cmd) begin
          state_next = ST_CONN;
        end
      end
      ST_ANSWER: begin
        if (dcd_s || RX_VALID) begin
          state_next = ST_CONN;
        end else if (ans_timeout) begin
          state_next = ST_DROP;
        end
      end
      ST_CONN: begin
        if (!dcd_s || eot_rx) begin
          state_next = ST_DROP;
        end else if (hang_cmd || rx_lim_hit) begin
          state_next = (eot_cnt_reg != 4'h0) ? ST_EOT : ST_DRAIN;
        end
      end
      ST_EOT: begin
        if (tx_fire && eot_left_reg == 4'h1) begin
          state_next = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        if (ms_cnt_reg > char_ms_reg) begin
          state_next = ST_DROP;
        end
      end
      ST_DROP: begin
        if (drop_done) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  wire in_call = (state_next == ST_ANSWER) || (state_next == ST_CONN) ||
                 (state_next == ST_EOT) || (state_next == ST_DRAIN);
  wire keyed = (state_next == ST_CONN) || (state_next == ST_EOT) ||
               (state_next == ST_DRAIN);
  wire dtr_next = leased || in_call;
  wire rts_next = (state_next == ST_IDLE) ? busy_out :
                  (keyed && ctrl_reg[CTRL_RTS]);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_reg <= ST_IDLE;
      dtr_reg <= 1'b0;
      rts_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      dtr_reg <= dtr_next;
      rts_reg <= rts_next;
    end
  end

  // Timers restart on every state change so each wait is measured from its own entry.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ms_cnt_reg <= 16'h0000;
      s_cnt_reg <= 8'h00;
    end else if (st_change) begin
      ms_cnt_reg <= 16'h0000;
      s_cnt_reg <= 8'h00;
    end else begin
      if (tk.ms_tick && ms_cnt_reg != 16'hffff) begin
        ms_cnt_reg <= ms_cnt_reg + 16'h0001;
      end
      if (tk.s_tick && s_cnt_reg != 8'hff) begin
        s_cnt_reg <= s_cnt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      eot_left_reg <= 4'h0;
      rx_cnt_reg <= 16'h0000;
    end else begin
      if (state_next == ST_EOT && state_reg != ST_EOT) begin
        eot_left_reg <= eot_cnt_reg;
      end else if (tx_fire) begin
        eot_left_reg <= eot_left_reg - 4'h1;
      end
      if (state_reg != ST_CONN) begin
        rx_cnt_reg <= 16'h0000;
      end else if (RX_VALID && rx_cnt_reg != 16'hffff) begin
        rx_cnt_reg <= rx_cnt_reg + 16'h0001;
      end
    end
  end

  assign TX_VALID = (state_reg == ST_EOT) && (eot_left_reg != 4'h0);
  assign TX_DATA = EOT_CHAR;

  wire [IRQ_W-1:0] ev;
  assign ev[IRQ_CARRIER] = (state_reg == ST_CONN) && !dcd_s;
  assign ev[IRQ_EOT] = (state_reg == ST_CONN) && dcd_s && eot_rx;
  assign ev[IRQ_TIMEOUT] = (state_reg == ST_ANSWER) && (state_next == ST_DROP);
  assign ev[IRQ_ENDED] = (state_reg == ST_DROP) && (state_next == ST_IDLE);
  assign ev[IRQ_RING] = ri_s && !ri_d_reg;
  wire [IRQ_W-1:0] irq_clr = (WE && hit(ADDR, ADDR_IRQ_STAT)) ? WDATA[IRQ_W-1:0] : IRQ_RST;

  // A new event wins over a write-one-to-clear in the same cycle.
  assign irq_stat_next = (irq_stat_reg & ~irq_clr) | ev;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_reg <= CTRL_RST;
      eot_cnt_reg <= EOT_CNT_RST;
      char_ms_reg <= CHAR_MS_RST;
      rx_limit_reg <= RX_LIMIT_RST;
      irq_mask_reg <= IRQ_RST;
      irq_stat_reg <= IRQ_RST;
      ri_d_reg <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      ri_d_reg <= ri_s;
      if (wr_ctrl) begin
        ctrl_reg <= WDATA[3:0];
      end
      if (WE && hit(ADDR, ADDR_IRQ_MASK)) begin
        irq_mask_reg <= WDATA[IRQ_W-1:0];
      end
      if (WE && hit(ADDR, ADDR_EOT_CNT)) begin
        eot_cnt_reg <= WDATA[3:0];
      end
      if (WE && hit(ADDR, ADDR_CHAR_MS)) begin
        char_ms_reg <= WDATA[15:0];
      end
      if (WE && hit(ADDR, ADDR_RX_LIMIT)) begin
        rx_limit_reg <= WDATA[15:0];
      end
    end
  end

  wire [31:0] status_word = {25'h0, state_reg, pins_s};
  wire [31:0] rd_mux =
    hit(ADDR, ADDR_CTRL) ? {28'h0, ctrl_reg} :
    hit(ADDR, ADDR_STATUS) ? status_word :
    hit(ADDR, ADDR_IRQ_STAT) ? {27'h0, irq_stat_reg} :
    hit(ADDR, ADDR_IRQ_MASK) ? {27'h0, irq_mask_reg} :
    hit(ADDR, ADDR_EOT_CNT) ? {28'h0, eot_cnt_reg} :
    hit(ADDR, ADDR_CHAR_MS) ? {16'h0, char_ms_reg} :
    hit(ADDR, ADDR_RX_LIMIT) ? {16'h0, rx_limit_reg} : 32'h0;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rdata_reg <= 32'h0;
    end else begin
      rdata_reg <= RE ? rd_mux : 32'h0;
    end
  end

  assign RDATA = rdata_reg;
  assign DTR = dtr_reg;
  assign RTS = rts_reg;
  assign IRQ = |(irq_stat_reg & irq_mask_reg);

  // Raw cycle count of the drop phase, so the hang-up minimum is checked apart from the timer.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      drop_cyc_reg <= 32'h0;
    end else if (state_reg != ST_DROP) begin
      drop_cyc_reg <= 32'h0;
    end else begin
      drop_cyc_reg <= drop_cyc_reg + 32'h1;
    end
  end

  sequence s_drop_exit;
    state_reg == ST_DROP && state_next == ST_IDLE;
  endsequence

  sequence s_hang_plain;
    state_reg == ST_CONN && dcd_s && !eot_rx && hang_cmd && eot_cnt_reg == 4'h0;
  endsequence

  property p_drop_min;
    @(posedge CLK) disable iff (RST)
      s_drop_exit |-> drop_cyc_reg >= DROP_MIN_MS * MS_CYC && (leased || !dsr_s);
  endproperty
  a_drop_min: assert property (p_drop_min) else $error("drop ended early");

  property p_dtr_off;
    @(posedge CLK) disable iff (RST)
      (state_reg == ST_DROP && !leased) ##1 (state_reg == ST_DROP) |-> !DTR;
  endproperty
  a_dtr_off: assert property (p_dtr_off) else $error("DTR on during drop");

  property p_leased;
    @(posedge CLK) disable iff (RST)
      state_reg == ST_DROP && $past(state_reg) == ST_DROP && leased |-> DTR && !RTS;
  endproperty
  a_leased: assert property (p_leased) else $error("leased drop wrong");

  property p_drain;
    @(posedge CLK) disable iff (RST)
      state_reg == ST_DRAIN && state_next == ST_DROP |-> ms_cnt_reg > char_ms_reg;
  endproperty
  a_drain: assert property (p_drain) else $error("drain cut short");

  property p_eot_last;
    @(posedge CLK) disable iff (RST)
      state_reg == ST_EOT && tx_fire && eot_left_reg == 4'h1 |=> state_reg == ST_DRAIN;
  endproperty
  a_eot_last: assert property (p_eot_last) else $error("no drain after EOT");

  property p_rx_end;
    @(posedge CLK) disable iff (RST)
      state_reg == ST_CONN && (eot_rx || !dcd_s) |=> state_reg == ST_DROP ##1 !DTR || leased;
  endproperty
  a_rx_end: assert property (p_rx_end) else $error("call not ended");

  property p_answer_to;
    @(posedge CLK) disable iff (RST)
      state_reg == ST_ANSWER && !dcd_s && !RX_VALID && ans_timeout |=>
        state_reg == ST_DROP && irq_stat_reg[IRQ_TIMEOUT];
  endproperty
  a_answer_to: assert property (p_answer_to) else $error("answer timeout missed");

  property p_busy;
    @(posedge CLK) disable iff (RST)
      state_reg == ST_IDLE && $past(state_reg) == ST_IDLE |-> RTS == $past(busy_out);
  endproperty
  a_busy: assert property (p_busy) else $error("busy-out wrong");

  property p_hang;
    @(posedge CLK) disable iff (RST)
      s_hang_plain |=> state_reg == ST_DRAIN && ms_cnt_reg == 16'h0000;
  endproperty
  a_hang: assert property (p_hang) else $error("hang-up skipped drain");

  property p_timer_clear;
    @(posedge CLK) disable iff (RST)
      st_change |=> ms_cnt_reg == 16'h0000 && s_cnt_reg == 8'h00;
  endproperty
  a_timer_clear: assert property (p_timer_clear) else $error("timer not cleared");
endmodule : call_term_ctrl

// *** testbench/modem_set_model.sv ***
// Purpose: Data set seen by the call control, for simulation.
// Assumes: Delays are counted in system clock cycles.
// Notes: Set ready lingers after terminal ready drops, as a send-disconnect set does.
`timescale 1ns/10ps
module modem_set_model #(
  parameter int S_CYC = 100,
  parameter bit SHORT_SPACE = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Line conditions from the bench
  input wire logic carrier,
  input wire logic ring,
  input wire logic slow,
  // Interface signals
  input wire logic dtr,
  input wire logic rts,
  output logic dsr,
  output logic dcd,
  output logic cts,
  output logic ri
);
  localparam int SPACE_CYC = SHORT_SPACE ? 2 * S_CYC / 5 : 3 * S_CYC / 2;
  localparam int ABORT_CYC = 12 * S_CYC;
  int unsigned hold_cnt;
  int unsigned space_cnt;
  int unsigned wait_cnt;
  logic far_gone;
  logic aborted;
  logic [3:0] car_dly;
  // Clear to send rises with carrier, so only carrier need be watched.
  assign cts = dcd;
  // A set made busy never shows ringing, so a hunting group passes it by.
  assign ri = ring && !rts;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dsr <= 1'b0;
      dcd <= 1'b0;
      car_dly <= '0;
      hold_cnt <= 0;
      space_cnt <= 0;
      wait_cnt <= 0;
      far_gone <= 1'b0;
      aborted <= 1'b0;
    end else begin
      car_dly <= {car_dly[2:0], carrier};
      dcd <= car_dly[3] && !far_gone;
      if (dtr) begin
        dsr <= !aborted;
        hold_cnt <= slow ? 3000 : 3;
        space_cnt <= 0;
        far_gone <= 1'b0;
      end else if (hold_cnt != 0) begin
        hold_cnt <= hold_cnt - 1;
        space_cnt <= space_cnt + 1;
      end else begin
        dsr <= 1'b0;
      end
      // A long enough run of our disconnect space makes the far set hang up.
      if (!dtr && space_cnt >= SPACE_CYC) begin
        far_gone <= 1'b1;
      end
      if (!dtr) begin
        wait_cnt <= 0;
        aborted <= 1'b0;
      end else if (dcd) begin
        wait_cnt <= 0;
      end else if (wait_cnt >= ABORT_CYC) begin
        aborted <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
    end
  end
endmodule : modem_set_model

// *** testbench/test_modem_call_termination_control.sv ***
// Purpose: Self-checking bench for the call termination control.
// Assumes: Ten clocks per ms tick and ten ms ticks per second tick.
// Notes: Reads queue their expected data; a monitor compares it in the answer cycle.
`timescale 1ns/10ps
module test_modem_call_termination_control;
  import modem_pkg::*;
  localparam int MSC = 10;
  localparam int SC = 100;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = '0;
  logic [31:0] wdata = '0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic rx_valid = 1'b0;
  logic [7:0] rx_data = '0;
  logic tx_ready = 1'b0;
  logic carrier = 1'b0;
  logic ring = 1'b0;
  logic slow = 1'b0;
  logic [31:0] rdata;
  logic dtr, rts, dsr, dcd, cts, ri, tx_valid, irq;
  logic [7:0] tx_data;
  logic rd_pend = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] seed = 32'hdf4c6f69;
  logic [31:0] r, c;
  int n_fail = 0;
  int total_checks = 0;
  int n_eot = 0;
  int e0;
  logic [2:0] st_tab [3] = '{3'b111, 3'b111, 3'b110};
  logic [3:0] pin_tab [3] = '{4'b0110, 4'b0000, 4'b0111};
  logic [31:0] irq_tab [3] = '{32'h1a, 32'h19, 32'h18};

  always #20 clk = ~clk;

  call_term_ctrl #(.MS_CYC(MSC), .MS_S(10)) dut (.CLK(clk), .RST(rst), .ADDR(addr),
    .WDATA(wdata), .WE(we), .RE(re), .RDATA(rdata), .DTR(dtr), .RTS(rts), .DSR(dsr),
    .DCD(dcd), .CTS(cts), .RI(ri), .RX_VALID(rx_valid), .RX_DATA(rx_data),
    .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_READY(tx_ready), .IRQ(irq));
  modem_set_model #(.S_CYC(SC)) dset (.clk(clk), .rst(rst), .carrier(carrier), .ring(ring),
    .slow(slow),
    .dtr(dtr), .rts(rts), .dsr(dsr), .dcd(dcd), .cts(cts), .ri(ri));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      n_fail++;
      $display("[ERR] t=%0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic results();
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // A idle cycle follows each strobe so no strobe is driven twice in one step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    exp_q.push_back(want);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    @(posedge clk);
  endtask : rd
  task automatic st(input logic [2:0] s, input logic [3:0] p);
    rd(ADDR_STATUS, {25'h0, s, p});
  endtask : st
  task automatic pins(input logic [1:0] w);
    check({30'h0, dtr, rts}, {30'h0, w});
  endtask : pins
  task automatic rx(input logic [7:0] ch);
    rx_data <= ch;
    rx_valid <= 1'b1;
    @(posedge clk);
    rx_valid <= 1'b0;
    @(posedge clk);
  endtask : rx
  task automatic connect();
    ring <= 1'b1;
    carrier <= 1'b1;
    cyc(20);
    ring <= 1'b0;
    cyc(10);
  endtask : connect

  always @(posedge clk) begin
    if (rd_pend) begin
      check(rdata, exp_q.pop_front());
    end
    rd_pend <= re;
  end
  // The transmitter stalls at random to stretch the end-of-transmission run.
  always @(posedge clk) begin
    r = rnd();
    tx_ready <= r[0];
    if (tx_valid && tx_ready) begin
      n_eot <= n_eot + 1;
      check({24'h0, tx_data}, {24'h0, EOT_CHAR});
    end
  end

  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    results();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({29'h0, dtr, rts, irq}, 32'h0);
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_EOT_CNT, 32'h3);
    rd(ADDR_CHAR_MS, 32'h64);
    rd(ADDR_RX_LIMIT, 32'h0);
    rd(ADDR_IRQ_MASK, 32'h0);
    wr(8'h1c, rnd());
    rd(8'h1c, 32'h0);
    $display("Done: reset values");
    slow <= 1'b1;
    wr(ADDR_IRQ_MASK, 32'h1f);
    wr(ADDR_CTRL, 32'h5);
    ring <= 1'b1;
    cyc(5);
    ring <= 1'b0;
    cyc(8 * SC);
    st(3'b001, 4'b0001);
    pins(2'b10);
    cyc(2 * SC + 20);
    st(3'b111, 4'b0001);
    pins(2'b00);
    rd(ADDR_IRQ_STAT, 32'h14);
    wr(ADDR_IRQ_STAT, 32'h14);
    rd(ADDR_IRQ_STAT, 32'h0);
    check({31'h0, irq}, 32'h0);
    cyc(150 * MSC);
    st(3'b111, 4'b0001);
    cyc(200 * MSC);
    st(3'b000, 4'b0000);
    rd(ADDR_IRQ_STAT, 32'h08);
    check({31'h0, irq}, 32'h1);
    wr(ADDR_IRQ_MASK, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(ADDR_IRQ_MASK, 32'h08);
    check({31'h0, irq}, 32'h1);
    wr(ADDR_IRQ_STAT, 32'h08);
    check({31'h0, irq}, 32'h0);
    $display("Done: answer timeout");
    slow <= 1'b0;
    wr(ADDR_EOT_CNT, 32'h2);
    wr(ADDR_CHAR_MS, 32'h5);
    connect();
    st(3'b011, 4'b0111);
    pins(2'b11);
    e0 = n_eot;
    wr(ADDR_CTRL, 32'h15);
    for (int i = 0; i < 400 && n_eot < e0 + 2; i++) @(posedge clk);
    check(n_eot - e0, 32'h2);
    cyc(4 * MSC);
    pins(2'b11);
    cyc(4 * MSC);
    pins(2'b00);
    st(3'b111, 4'b0110);
    cyc(120 * MSC);
    rd(ADDR_IRQ_STAT, 32'h18);
    wr(ADDR_IRQ_STAT, 32'h1f);
    carrier <= 1'b0;
    $display("Done: hang-up");
    wr(ADDR_EOT_CNT, 32'h0);
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_RX_LIMIT, (k == 2) ? 32'h3 : 32'h0);
      connect();
      for (int j = 0; j < ((k == 2) ? 3 : 2); j++) begin
        c = rnd();
        rx((c[7:0] == EOT_CHAR) ? 8'h41 : c[7:0]);
      end
      if (k == 0) rx(EOT_CHAR);
      if (k == 1) carrier <= 1'b0;
      cyc(30);
      st(st_tab[k], pin_tab[k]);
      cyc(130 * MSC);
      rd(ADDR_IRQ_STAT, irq_tab[k]);
      wr(ADDR_IRQ_STAT, 32'h1f);
      carrier <= 1'b0;
    end
    $display("Done: disconnect causes");
    wr(ADDR_CTRL, 32'h9);
    ring <= 1'b1;
    cyc(10);
    ring <= 1'b0;
    pins(2'b01);
    st(3'b000, 4'b0000);
    rd(ADDR_IRQ_STAT, 32'h0);
    wr(ADDR_RX_LIMIT, 32'h0);
    wr(ADDR_CTRL, 32'h0e);
    carrier <= 1'b1;
    cyc(10);
    pins(2'b11);
    wr(ADDR_CTRL, 32'h2e);
    cyc(10);
    st(3'b011, 4'b0111);
    wr(ADDR_CTRL, 32'h1e);
    cyc(8 * MSC);
    pins(2'b10);
    st(3'b111, 4'b0111);
    cyc(120 * MSC);
    pins(2'b11);
    $display("Done: leased line");
    cyc(4);
    results();
  end
endmodule : test_modem_call_termination_control
